// ---- src/cabe_exec_core.v ----
// apb-controlled execution core for arithmetic, logic, jump, call, return and skip
// Function
// [RULE_01] register add stores the 8-bit sum, the carry form adds C, sets Z C N V H, 1 cycle.
// [RULE_02] word add adds the constant to a register pair, sets Z C N V S, 2 cycles.
// [RULE_03] word subtract takes the constant from the pair, writes back, sets Z C N V S, 2 cycles.
// [RULE_04] plain subtract by register or constant stores the difference, sets Z C N V H, 1 cycle.
// [RULE_05] subtract with borrow also takes away C, register and constant forms, 1 cycle.
// [RULE_06] and of register or constant and xor of registers store the result, set Z N V, 1 cycle.
// [RULE_07] or of register or constant stores the result, sets Z N V, 1 cycle.
// [RULE_08] set-mask ors a constant in, clear-mask ands with 0xff minus it, set Z N V, 1 cycle.
// [RULE_09] self check ands a register with itself, leaves it, sets Z N V, 1 cycle.
// [RULE_10] all-ones load writes 0xff with no flag change; clear xors the register with itself.
// [RULE_11] pointer jump loads the counter from the pointer pair, no flags, 2 cycles.
// [RULE_12] pointer call pushes the return address, loads the pointer pair, no flags, 3 cycles.
// [RULE_13] equal skip advances past the next instruction by 2 or 3 words, no flags, 1/2/3 cycles.
// [RULE_14] relative jump and call go to counter plus offset plus one; call pushes; 2 and 3 cycles.
// [RULE_15] return and interrupt return pop the counter in 4 cycles; the latter sets I.
// [RULE_16] ones invert is 0xff minus value, twos invert is 0x00 minus value with H, 1 cycle.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "cabe_defines.vh"
module cabe_exec_core (
   input  wire        clk_sys,
   input  wire        rst_b,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr
);
   reg  [7:0]  gpr [0:31];
   reg  [15:0] stackMem [0:15];
   reg  [15:0] programCounter;
   reg  [3:0]  stackPtr;
   reg  [7:0]  sreg;
   reg  [31:0] cmdReg;
   reg         busy;
   reg  [2:0]  cycLeft;
   reg  [4:0]  gprSel;
   integer     i;

   ////////////////////////////////////////////////////////////////////////////
   // command decode
   wire [4:0]  op      = cmdReg[`CABE_CMD_OP_LSB +: 5];
   wire [4:0]  rd      = cmdReg[`CABE_CMD_RD_LSB +: 5];
   wire [4:0]  srcIdx  = cmdReg[`CABE_CMD_SRC_LSB +: 5];
   wire [11:0] imm     = cmdReg[`CABE_CMD_IMM_LSB +: 12];
   wire [4:0]  rdHigh  = {rd[4:1], 1'b1};
   wire [4:0]  rdLow   = {rd[4:1], 1'b0};
   wire [7:0]  valRd   = gpr[rd];
   wire [7:0]  valSrc  = gpr[srcIdx];
   wire [15:0] pairVal = {gpr[rdHigh], gpr[rdLow]};
   wire [15:0] ptrPair = {gpr[5'd31], gpr[5'd30]};
   wire [15:0] pcNext  = programCounter + 16'h0001;
   wire [15:0] relDest = pcNext + {{4{imm[11]}}, imm};
   wire [3:0]  spUp    = stackPtr + 4'h1;

   reg  [7:0]  aluA;
   reg  [7:0]  aluB;
   reg         aluCin;
   reg         aluSub;
   wire [7:0]  aluRes;
   wire        aluC;
   wire        aluH;
   wire        aluV;

   cabe_addsub u_addsub (
      .opA      (aluA),
      .opB      (aluB),
      .carryIn  (aluCin),
      .subtract (aluSub),
      .result   (aluRes),
      .carryOut (aluC),
      .halfOut  (aluH),
      .overOut  (aluV)
   );

   always @* begin
      aluA   = valRd;
      aluB   = valSrc;
      aluCin = 1'b0;
      aluSub = 1'b0;
      case (op)
         `CABE_OP_ADC: aluCin = sreg[`CABE_FLAG_C];
         `CABE_OP_SUB: aluSub = 1'b1;
         `CABE_OP_SUBK: begin
            aluSub = 1'b1;
            aluB   = imm[7:0];
         end
         `CABE_OP_SBW: begin
            aluSub = 1'b1;
            aluCin = sreg[`CABE_FLAG_C];
         end
         `CABE_OP_SBWI: begin
            aluSub = 1'b1;
            aluCin = sreg[`CABE_FLAG_C];
            aluB   = imm[7:0];
         end
         `CABE_OP_INV2: begin
            aluSub = 1'b1;
            aluA   = 8'h00;
            aluB   = valRd;
         end
         default: aluCin = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // word arithmetic on the register pair
   wire        wordSub  = (op == `CABE_OP_WSUB);
   wire [15:0] wordRes  = wordSub ? (pairVal - {10'h000, imm[5:0]})
                                  : (pairVal + {10'h000, imm[5:0]});
   wire        wordV    = wordSub ? (pairVal[15] & ~wordRes[15])
                                  : (~pairVal[15] & wordRes[15]);
   wire        wordC    = wordSub ? (wordRes[15] & ~pairVal[15])
                                  : (~wordRes[15] & pairVal[15]);

   ////////////////////////////////////////////////////////////////////////////
   // result and flag selection
   reg  [7:0]  next_res;
   reg         next_wrRd;
   reg         next_wrPair;
   reg  [7:0]  next_sreg;
   reg  [15:0] next_pc;
   reg         next_push;
   reg         next_pop;
   reg  [7:0]  logicRes;
   reg         logicFlags;

   always @* begin
      next_res    = 8'h00;
      next_wrRd   = 1'b0;
      next_wrPair = 1'b0;
      next_sreg   = sreg;
      next_pc     = pcNext;
      next_push   = 1'b0;
      next_pop    = 1'b0;
      logicRes    = 8'h00;
      logicFlags  = 1'b0;
      case (op)
         `CABE_OP_ADD, `CABE_OP_ADC, `CABE_OP_SUB, `CABE_OP_SUBK,
         `CABE_OP_SBW, `CABE_OP_SBWI, `CABE_OP_INV2: begin
            next_res  = aluRes;  // see [RULE_01] see [RULE_04] see [RULE_05] see [RULE_16]
            next_wrRd = 1'b1;
            next_sreg[`CABE_FLAG_Z] = (aluRes == 8'h00);
            next_sreg[`CABE_FLAG_C] = aluC;
            next_sreg[`CABE_FLAG_N] = aluRes[7];
            next_sreg[`CABE_FLAG_V] = aluV;
            next_sreg[`CABE_FLAG_H] = aluH;
         end
         `CABE_OP_WADD, `CABE_OP_WSUB: begin
            next_wrPair = 1'b1;  // see [RULE_02] see [RULE_03]
            next_sreg[`CABE_FLAG_Z] = (wordRes == 16'h0000);
            next_sreg[`CABE_FLAG_C] = wordC;
            next_sreg[`CABE_FLAG_N] = wordRes[15];
            next_sreg[`CABE_FLAG_V] = wordV;
            next_sreg[`CABE_FLAG_S] = wordRes[15] ^ wordV;
         end
         `CABE_OP_AND: begin
            logicRes   = valRd & valSrc;  // see [RULE_06]
            logicFlags = 1'b1;
            next_wrRd  = 1'b1;
         end
         `CABE_OP_ANDK: begin
            logicRes   = valRd & imm[7:0];  // see [RULE_06]
            logicFlags = 1'b1;
            next_wrRd  = 1'b1;
         end
         `CABE_OP_XOR: begin
            logicRes   = valRd ^ valSrc;  // see [RULE_06]
            logicFlags = 1'b1;
            next_wrRd  = 1'b1;
         end
         `CABE_OP_OR: begin
            logicRes   = valRd | valSrc;  // see [RULE_07]
            logicFlags = 1'b1;
            next_wrRd  = 1'b1;
         end
         `CABE_OP_ORK, `CABE_OP_SETM: begin
            logicRes   = valRd | imm[7:0];  // see [RULE_07] see [RULE_08]
            logicFlags = 1'b1;
            next_wrRd  = 1'b1;
         end
         `CABE_OP_CLRM: begin
            logicRes   = valRd & (`CABE_ALL_ONES - imm[7:0]);  // see [RULE_08]
            logicFlags = 1'b1;
            next_wrRd  = 1'b1;
         end
         `CABE_OP_CHK: begin
            logicRes   = valRd & valRd;  // see [RULE_09]
            logicFlags = 1'b1;
         end
         `CABE_OP_CLR: begin
            logicRes   = valRd ^ valRd;  // see [RULE_10]
            logicFlags = 1'b1;
            next_wrRd  = 1'b1;
         end
         `CABE_OP_INV1: begin
            logicRes   = `CABE_ALL_ONES - valRd;  // see [RULE_16]
            logicFlags = 1'b1;
            next_wrRd  = 1'b1;
            next_sreg[`CABE_FLAG_C] = 1'b1;
         end
         `CABE_OP_ONES: begin
            next_res  = `CABE_ALL_ONES;  // see [RULE_10]
            next_wrRd = 1'b1;
         end
         `CABE_OP_RGO: next_pc = relDest;  // see [RULE_14]
         `CABE_OP_RSUB: begin
            next_pc   = relDest;  // see [RULE_14]
            next_push = 1'b1;
         end
         `CABE_OP_PGO: next_pc = ptrPair;  // see [RULE_11]
         `CABE_OP_PSUB: begin
            next_pc   = ptrPair;  // see [RULE_12]
            next_push = 1'b1;
         end
         `CABE_OP_RET: begin
            next_pc  = stackMem[spUp];  // see [RULE_15]
            next_pop = 1'b1;
         end
         `CABE_OP_IRET: begin
            next_pc  = stackMem[spUp];  // see [RULE_15]
            next_pop = 1'b1;
            next_sreg[`CABE_FLAG_I] = 1'b1;
         end
         `CABE_OP_SKIP: begin
            if (valRd == valSrc) begin
               next_pc = cmdReg[`CABE_CMD_WIDE_BIT] ? programCounter + 16'h0003
                                                    : programCounter + 16'h0002;  // see [RULE_13]
            end
         end
         default: next_pc = pcNext;
      endcase
      if (logicFlags) begin
         next_res = logicRes;
         next_sreg[`CABE_FLAG_Z] = (logicRes == 8'h00);
         next_sreg[`CABE_FLAG_N] = logicRes[7];
         next_sreg[`CABE_FLAG_V] = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // cycle count of an incoming command
   wire [4:0] inOp  = pwdata[`CABE_CMD_OP_LSB +: 5];
   wire [4:0] inRd  = pwdata[`CABE_CMD_RD_LSB +: 5];
   wire [4:0] inSrc = pwdata[`CABE_CMD_SRC_LSB +: 5];
   reg  [2:0] inCyc;

   always @* begin
      case (inOp)
         `CABE_OP_WADD, `CABE_OP_WSUB: inCyc = {1'b0, `CABE_CYC_WORD};  // see [RULE_02]
         `CABE_OP_RGO, `CABE_OP_PGO:   inCyc = {1'b0, `CABE_CYC_JUMP};  // see [RULE_11]
         `CABE_OP_RSUB, `CABE_OP_PSUB: inCyc = {1'b0, `CABE_CYC_CALL};  // see [RULE_12]
         `CABE_OP_RET, `CABE_OP_IRET:  inCyc = `CABE_CYC_RET;  // see [RULE_15]
         `CABE_OP_SKIP: begin
            if (gpr[inRd] != gpr[inSrc])
               inCyc = 3'd1;
            else if (pwdata[`CABE_CMD_WIDE_BIT])
               inCyc = 3'd3;
            else
               inCyc = 3'd2;  // see [RULE_13]
         end
         default: inCyc = {1'b0, `CABE_CYC_ALU};
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb slave
   wire access  = psel & penable;
   // writes wait while a command runs so no operand changes under it
   wire canTake = ~(pwrite & busy);
   wire wrDone  = access & pready & pwrite & ~pslverr;
   wire known   = (paddr == `CABE_OFS_CMD) || (paddr == `CABE_OFS_STATUS) ||
                  (paddr == `CABE_OFS_PCNT) || (paddr == `CABE_OFS_SP) ||
                  (paddr == `CABE_OFS_GPR_SEL) || (paddr == `CABE_OFS_GPR_DATA);
   reg  [31:0] rdMux;

   always @* begin
      case (paddr)
         `CABE_OFS_CMD:      rdMux = cmdReg;
         `CABE_OFS_STATUS:   rdMux = {23'h000000, busy, sreg};
         `CABE_OFS_PCNT:     rdMux = {16'h0000, programCounter};
         `CABE_OFS_SP:       rdMux = {28'h0000000, stackPtr};
         `CABE_OFS_GPR_SEL:  rdMux = {27'h0000000, gprSel};
         `CABE_OFS_GPR_DATA: rdMux = {24'h000000, gpr[gprSel]};
         default:            rdMux = 32'h00000000;
      endcase
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else if (access && !pready && canTake) begin
         pready  <= 1'b1;
         pslverr <= ~known;
         prdata  <= pwrite ? 32'h00000000 : rdMux;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // architectural state
   wire execNow = busy && (cycLeft == 3'd1);

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (i = 0; i < 32; i = i + 1)
            gpr[i] <= 8'h00;
         for (i = 0; i < 16; i = i + 1)
            stackMem[i] <= 16'h0000;
         programCounter <= `CABE_RST_PCNT;
         stackPtr       <= `CABE_RST_SP;
         sreg           <= `CABE_RST_SREG;
         cmdReg         <= 32'h00000000;
         busy           <= 1'b0;
         cycLeft        <= 3'd0;
         gprSel         <= 5'h00;
      end else if (wrDone) begin
         case (paddr)
            `CABE_OFS_CMD: begin
               cmdReg  <= pwdata;
               busy    <= 1'b1;
               cycLeft <= inCyc;
            end
            `CABE_OFS_STATUS:   sreg           <= pwdata[7:0];
            `CABE_OFS_PCNT:     programCounter <= pwdata[15:0];
            `CABE_OFS_SP:       stackPtr       <= pwdata[3:0];
            `CABE_OFS_GPR_SEL:  gprSel         <= pwdata[4:0];
            `CABE_OFS_GPR_DATA: gpr[gprSel]    <= pwdata[7:0];
            default:            gprSel         <= gprSel;
         endcase
      end else if (busy) begin
         cycLeft <= cycLeft - 3'd1;
         if (execNow) begin
            busy           <= 1'b0;
            sreg           <= next_sreg;
            programCounter <= next_pc;
            if (next_wrRd)
               gpr[rd] <= next_res;
            if (next_wrPair) begin
               gpr[rdLow]  <= wordRes[7:0];
               gpr[rdHigh] <= wordRes[15:8];
            end
            if (next_push) begin
               stackMem[stackPtr] <= pcNext;  // see [RULE_12] see [RULE_14]
               stackPtr           <= stackPtr - 4'h1;
            end
            if (next_pop)
               stackPtr <= spUp;  // see [RULE_15]
         end
      end
   end
endmodule // cabe_exec_core
`default_nettype wire

// ---- src/cabe_defines.vh ----
// constants shared by the execution core: register map, fields, codes, cycle counts
`ifndef CABE_DEFINES_VH
`define CABE_DEFINES_VH

// apb register byte offsets
`define CABE_OFS_CMD      8'h00
`define CABE_OFS_STATUS   8'h04
`define CABE_OFS_PCNT     8'h08
`define CABE_OFS_SP       8'h0c
`define CABE_OFS_GPR_SEL  8'h10
`define CABE_OFS_GPR_DATA 8'h14

// command word fields
`define CABE_CMD_OP_LSB   0
`define CABE_CMD_RD_LSB   5
`define CABE_CMD_SRC_LSB  10
`define CABE_CMD_IMM_LSB  16
`define CABE_CMD_WIDE_BIT 28

// status flag positions
`define CABE_FLAG_C 0
`define CABE_FLAG_Z 1
`define CABE_FLAG_N 2
`define CABE_FLAG_V 3
`define CABE_FLAG_S 4
`define CABE_FLAG_H 5
`define CABE_FLAG_I 7
`define CABE_BUSY_BIT 8

// reset values and the all-ones constant
`define CABE_RST_SREG 8'h00
`define CABE_RST_PCNT 16'h0000
`define CABE_RST_SP   4'hf
`define CABE_ALL_ONES 8'hff

// operation codes
`define CABE_OP_ADD   5'h00
`define CABE_OP_ADC   5'h01
`define CABE_OP_WADD  5'h02
`define CABE_OP_SUB   5'h03
`define CABE_OP_SUBK  5'h04
`define CABE_OP_SBW   5'h05
`define CABE_OP_SBWI  5'h06
`define CABE_OP_WSUB  5'h07
`define CABE_OP_AND   5'h08
`define CABE_OP_ANDK  5'h09
`define CABE_OP_OR    5'h0a
`define CABE_OP_ORK   5'h0b
`define CABE_OP_XOR   5'h0c
`define CABE_OP_INV1  5'h0d
`define CABE_OP_INV2  5'h0e
`define CABE_OP_SETM  5'h0f
`define CABE_OP_CLRM  5'h10
`define CABE_OP_CHK   5'h11
`define CABE_OP_CLR   5'h12
`define CABE_OP_ONES  5'h13
`define CABE_OP_RGO   5'h14
`define CABE_OP_PGO   5'h15
`define CABE_OP_RSUB  5'h16
`define CABE_OP_PSUB  5'h17
`define CABE_OP_RET   5'h18
`define CABE_OP_IRET  5'h19
`define CABE_OP_SKIP  5'h1a

// cycle counts
`define CABE_CYC_ALU  2'd1
`define CABE_CYC_WORD 2'd2
`define CABE_CYC_JUMP 2'd2
`define CABE_CYC_CALL 2'd3
`define CABE_CYC_RET  3'd4

`endif

// ---- src/cabe_addsub.v ----
// 8-bit adder/subtractor with carry, half-carry and overflow
`timescale 1ns/100ps
`default_nettype none
module cabe_addsub (
   input  wire [7:0] opA,
   input  wire [7:0] opB,
   input  wire       carryIn,
   input  wire       subtract,
   output wire [7:0] result,
   output wire       carryOut,
   output wire       halfOut,
   output wire       overOut
);
   wire [8:0] full;
   wire [4:0] nib;
   assign full = subtract ? ({1'b0, opA} - {1'b0, opB} - {8'h00, carryIn})
                          : ({1'b0, opA} + {1'b0, opB} + {8'h00, carryIn});
   assign nib  = subtract ? ({1'b0, opA[3:0]} - {1'b0, opB[3:0]} - {4'h0, carryIn})
                          : ({1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn});
   assign result   = full[7:0];
   // for subtraction these are borrows
   assign carryOut = full[8];
   assign halfOut  = nib[4];
   assign overOut  = subtract ? ((opA[7] != opB[7]) && (full[7] != opA[7]))
                              : ((opA[7] == opB[7]) && (full[7] != opA[7]));
endmodule // cabe_addsub
`default_nettype wire

// ---- test/cabe_exec_sva.sv ----
// concurrent checks on the apb port of the execution core
`timescale 1ns/100ps
`default_nettype none
`include "cabe_defines.vh"
module cabe_exec_sva (
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////////
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside an access phase");
   err_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("pslverr without pready or with data");
   access_wait_a: assert property ($rose(penable) && psel |-> !pready)
      else $error("no wait cycle in access phase");
   // longest command holds a write off for four cycles
   answer_bound_a: assert property ($rose(penable) && psel |-> ##[1:6] pready)
      else $error("access not answered in time");
   unmapped_err_a: assert property (pready && paddr > `CABE_OFS_GPR_DATA |-> pslverr)
      else $error("unmapped access without pslverr");
   mapped_ok_a: assert property (pready && paddr <= `CABE_OFS_GPR_DATA
      && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("pslverr on a mapped register");
   status_width_a: assert property (pready && !pwrite && paddr == `CABE_OFS_STATUS
      |-> prdata[31:9] == 23'h0)
      else $error("status high bits not zero");
   cover property (pready && pwrite && paddr == `CABE_OFS_CMD);
   cover property (pready && !pwrite && paddr == `CABE_OFS_PCNT);
   cover property (pslverr);
endmodule // cabe_exec_sva
`default_nettype wire

// ---- test/cabe_prog_mem.sv ----
// program memory model holding the branch test program
`timescale 1ns/100ps
`default_nettype none
`include "cabe_defines.vh"
module cabe_prog_mem (
   input  wire logic [15:0] fetchAddr,
   output var  logic [31:0] instrWord
);
   function automatic [31:0] enc(input [4:0] op, input [4:0] rd, input [4:0] rr,
                                 input [11:0] imm, input wide);
      enc = {3'b000, wide, imm, 1'b0, rr, rd, op};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      case (fetchAddr)
         16'h0000: instrWord = enc(`CABE_OP_RSUB, 5'd0, 5'd0, 12'h006, 1'b0);
         16'h0001: instrWord = enc(`CABE_OP_PGO, 5'd0, 5'd0, 12'h000, 1'b0);
         16'h0004: instrWord = enc(`CABE_OP_PSUB, 5'd0, 5'd0, 12'h000, 1'b0);
         16'h0005: instrWord = enc(`CABE_OP_SKIP, 5'd1, 5'd2, 12'h000, 1'b1);
         16'h0007: instrWord = enc(`CABE_OP_RGO, 5'd0, 5'd0, 12'hffc, 1'b0);
         16'h0008: instrWord = enc(`CABE_OP_SKIP, 5'd1, 5'd3, 12'h000, 1'b0);
         16'h0009: instrWord = enc(`CABE_OP_SKIP, 5'd1, 5'd2, 12'h000, 1'b0);
         16'h000b: instrWord = enc(`CABE_OP_IRET, 5'd0, 5'd0, 12'h000, 1'b0);
         16'h000c: instrWord = enc(`CABE_OP_RET, 5'd0, 5'd0, 12'h000, 1'b0);
         default:  instrWord = 32'h0000001f;
      endcase
   end
endmodule // cabe_prog_mem
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench: alu, word, branch and register map tests over apb
`timescale 1ns/100ps
`default_nettype none
`include "cabe_defines.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
   logic        clk_sys;
   logic        rst_b;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [15:0] fetchAddr;
   logic [31:0] instrWord;
   logic [33:0] noteQ[$];
   logic [33:0] note;
   logic [31:0] seed;
   logic [23:0] e;
   logic [16:0] r17;
   logic [7:0]  a;
   logic [7:0]  b;
   logic [7:0]  s0;
   logic [5:0]  k;
   logic [4:0]  op;
   logic        n;
   logic        v;
   int          err_total;
   int          tests_run;
   logic [4:0]  opList[18] = '{`CABE_OP_ADD, `CABE_OP_ADC, `CABE_OP_SUB, `CABE_OP_SUBK,
      `CABE_OP_SBW, `CABE_OP_SBWI, `CABE_OP_AND, `CABE_OP_ANDK, `CABE_OP_OR, `CABE_OP_ORK,
      `CABE_OP_XOR, `CABE_OP_INV1, `CABE_OP_INV2, `CABE_OP_SETM, `CABE_OP_CLRM,
      `CABE_OP_CHK, `CABE_OP_CLR, `CABE_OP_ONES};
   logic [15:0] pcList[9] = '{16'd7, 16'd4, 16'd12, 16'd5, 16'd8, 16'd9, 16'd11, 16'd1, 16'd12};
   logic        busyList[9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

   cabe_exec_core cabe_exec_core_inst (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   cabe_prog_mem cabe_prog_mem_inst (.fetchAddr(fetchAddr), .instrWord(instrWord));

   always #10 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // returns {flag mask, flags, result}
   function automatic [23:0] aluExp(input [4:0] o, input [7:0] x, input [7:0] y, input c);
      logic [8:0] r;
      logic       h;
      logic       w;
      logic       cc;
      logic [7:0] m;
      begin
         h = 1'b0;
         w = 1'b0;
         m = 8'h0e;
         cc = (o == `CABE_OP_ADC || o == `CABE_OP_SBW || o == `CABE_OP_SBWI) ? c : 1'b0;
         if (o == `CABE_OP_INV2) begin
            y = x;
            x = 8'h00;
         end
         case (o)
            `CABE_OP_ADD, `CABE_OP_ADC: begin
               m = 8'h2f;
               r = x + y + cc;
               h = ({1'b0, x[3:0]} + y[3:0] + cc) > 5'd15;
               w = (x[7] == y[7]) && (r[7] != x[7]);
            end
            `CABE_OP_SUB, `CABE_OP_SUBK, `CABE_OP_SBW, `CABE_OP_SBWI, `CABE_OP_INV2: begin
               m = 8'h2f;
               r = x - y - cc;
               h = {1'b0, x[3:0]} < ({1'b0, y[3:0]} + cc);
               w = (x[7] != y[7]) && (r[7] != x[7]);
            end
            `CABE_OP_AND, `CABE_OP_ANDK: r = x & y;
            `CABE_OP_OR, `CABE_OP_ORK, `CABE_OP_SETM: r = x | y;
            `CABE_OP_XOR: r = x ^ y;
            `CABE_OP_CLRM: r = x & ~y;
            `CABE_OP_CHK: r = {1'b0, x};
            `CABE_OP_CLR: r = 9'h000;
            `CABE_OP_INV1: begin
               m = 8'h0f;
               r = {1'b1, ~x};
            end
            default: begin
               m = 8'h00;
               r = 9'h0ff;
            end
         endcase
         aluExp = {m, 2'b00, h, 1'b0, w, r[7], r[7:0] == 8'h00, r[8], r[7:0]};
      end
   endfunction

   task xfer(input [7:0] ad, input wr, input [31:0] d, input [33:0] nt);
      begin
         noteQ.push_back(nt);
         psel <= 1'b1;
         penable <= 1'b0;
         paddr <= ad;
         pwrite <= wr;
         pwdata <= d;
         @(posedge clk_sys);
         penable <= 1'b1;
         @(posedge clk_sys);
         while (pready !== 1'b1) @(posedge clk_sys);
      end
   endtask

   task wr(input [7:0] ad, input [31:0] d);
      xfer(ad, 1'b1, d, 34'h0);
   endtask

   task rd(input [7:0] ad, input [31:0] x);
      xfer(ad, 1'b0, 32'h0, {2'b10, x});
   endtask

   task give_verdict;
      begin
         $display("comparisons %0d, mismatches %0d", tests_run, err_total);
         if (err_total == 0 && tests_run > 0) begin
            $display("Simulation passed");
         end else begin
            $display("Simulation failed");
         end
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      if (psel && penable && pready) begin
         note = noteQ.pop_front();
         `CHK(pslverr, note[32])
         if (note[33]) `CHK(prdata, note[31:0])
      end
   end

   initial begin
      repeat (6000) @(posedge clk_sys);
      err_total++;
      give_verdict();
   end

   initial begin
      clk_sys = 1'b0;
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fetchAddr = 16'h0;
      seed = 32'h8be598a9;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      rd(`CABE_OFS_STATUS, 32'h0);
      rd(`CABE_OFS_PCNT, 32'h0);
      rd(`CABE_OFS_SP, 32'hf);
      xfer(8'h18, 1'b0, 32'h0, {2'b11, 32'h0});
      xfer(8'hfc, 1'b1, 32'h5, {2'b01, 32'h0});
      $display("test reset and map done");
      for (int i = 0; i < 18; i++) begin
         seed = lfsr(seed);
         {s0, b, a} = seed[23:0];
         e = aluExp(opList[i], a, b, s0[0]);
         wr(`CABE_OFS_GPR_SEL, 32'd1);
         wr(`CABE_OFS_GPR_DATA, {24'h0, a});
         wr(`CABE_OFS_GPR_SEL, 32'd2);
         wr(`CABE_OFS_GPR_DATA, {24'h0, b});
         wr(`CABE_OFS_STATUS, {24'h0, s0});
         wr(`CABE_OFS_CMD, {8'h00, b, 1'b0, 5'd2, 5'd1, opList[i]});
         rd(`CABE_OFS_STATUS, {24'h0, (s0 & ~e[23:16]) | (e[15:8] & e[23:16])});
         wr(`CABE_OFS_GPR_SEL, 32'd1);
         rd(`CABE_OFS_GPR_DATA, {24'h0, e[7:0]});
      end
      $display("test alu done");
      for (int i = 0; i < 2; i++) begin
         op = i ? `CABE_OP_WSUB : `CABE_OP_WADD;
         seed = lfsr(seed);
         {s0, k} = {seed[31:24], seed[21:16]};
         r17 = i ? {1'b0, seed[15:0]} - k : {1'b0, seed[15:0]} + k;
         n = r17[15];
         v = i ? (seed[15] & !n) : (!seed[15] & n);
         wr(`CABE_OFS_GPR_SEL, 32'd24);
         wr(`CABE_OFS_GPR_DATA, {24'h0, seed[7:0]});
         wr(`CABE_OFS_GPR_SEL, 32'd25);
         wr(`CABE_OFS_GPR_DATA, {24'h0, seed[15:8]});
         wr(`CABE_OFS_STATUS, {24'h0, s0});
         wr(`CABE_OFS_CMD, {4'h0, 6'h00, k, 1'b0, 5'd0, 5'd24, op});
         rd(`CABE_OFS_STATUS, {23'h0, 1'b1, s0});
         wr(`CABE_OFS_GPR_SEL, 32'd25);
         rd(`CABE_OFS_GPR_DATA, {24'h0, r17[15:8]});
         wr(`CABE_OFS_GPR_SEL, 32'd24);
         rd(`CABE_OFS_GPR_DATA, {24'h0, r17[7:0]});
         rd(`CABE_OFS_STATUS,
            {24'h0, s0[7:5], n ^ v, v, n, r17[15:0] == 16'h0, r17[16]});
      end
      $display("test word done");
      wr(`CABE_OFS_GPR_SEL, 32'd30);
      wr(`CABE_OFS_GPR_DATA, 32'd12);
      wr(`CABE_OFS_GPR_SEL, 32'd31);
      wr(`CABE_OFS_GPR_DATA, 32'd0);
      for (int i = 1; i < 4; i++) begin
         wr(`CABE_OFS_GPR_SEL, i);
         wr(`CABE_OFS_GPR_DATA, (i == 3) ? 32'h11 : 32'h5a);
      end
      wr(`CABE_OFS_PCNT, 32'h0);
      wr(`CABE_OFS_SP, 32'hf);
      wr(`CABE_OFS_STATUS, 32'h2b);
      for (int i = 0; i < 9; i++) begin
         wr(`CABE_OFS_CMD, instrWord);
         fetchAddr <= pcList[i];
         rd(`CABE_OFS_STATUS, {23'h0, busyList[i], (i == 8) ? 8'hab : 8'h2b});
         wr(`CABE_OFS_GPR_SEL, 32'd0);
         rd(`CABE_OFS_PCNT, {16'h0, pcList[i]});
      end
      rd(`CABE_OFS_SP, 32'hf);
      $display("test branch done");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
      give_verdict();
   end
endmodule // testbench
bind cabe_exec_core cabe_exec_sva cabe_exec_sva_inst (.clk_sys(clk_sys), .rst_b(rst_b),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire
